// file: rtl/ofd_params.svh
// constants for the operand field decoder
`ifndef OFD_PARAMS_SVH
`define OFD_PARAMS_SVH
// major opcode nibble, bits 15..12
`define OFD_GRP_SYS 4'h0
`define OFD_GRP_NMD_ST 4'h1
`define OFD_GRP_NM_ST 4'h2
`define OFD_GRP_NM_ALU 4'h3
`define OFD_GRP_SHIFT 4'h4
`define OFD_GRP_NMD_LD 4'h5
`define OFD_GRP_NM_LD 4'h6
`define OFD_GRP_ADD_IMM 4'h7
`define OFD_GRP_R0_DISP 4'h8
`define OFD_GRP_PC_WORD 4'h9
`define OFD_GRP_BR12_A 4'hA
`define OFD_GRP_BR12_B 4'hB
`define OFD_GRP_GBR_IMM 4'hC
`define OFD_GRP_PC_LONG 4'hD
`define OFD_GRP_MOV_IMM 4'hE
// minor codes in group 0 (bits 3..0 or 7..0)
`define OFD_SYS_STC 4'h2
`define OFD_SYS_FAR_RELATIVE_JUMP 4'h3
`define OFD_SYS_IDX_ST_LO 4'h4
`define OFD_SYS_IDX_ST_HI 4'h6
`define OFD_SYS_MUL 4'h7
`define OFD_SYS_STS 4'hA
`define OFD_SYS_IDX_LD_LO 4'hC
`define OFD_SYS_IDX_LD_HI 4'hE
`define OFD_SYS_MAC 4'hF
`define OFD_SYS_COPY_T 8'h29
// minor codes in groups 2 and 6 (bits 3..0)
`define OFD_IND_HI 4'h2
`define OFD_AUTO_LO 4'h4
`define OFD_AUTO_HI 4'h6
// group 4 (bits 3..0; OFD_SH_TAS is matched in bits 7..4)
`define OFD_SH_MAC 4'hF
`define OFD_SH_STORE_LO 4'h2
`define OFD_SH_STORE_HI 4'h3
`define OFD_SH_LDS 4'h6
`define OFD_SH_LDS_DIRECT 4'hA
`define OFD_SH_LDC 4'h7
`define OFD_SH_LDC_DIRECT 4'hE
`define OFD_SH_JUMP 4'hB
`define OFD_SH_TAS 4'h1
// group 8 and C sub codes (bits 11..8)
`define OFD_R8_ST_HI 4'h1
`define OFD_R8_LD_LO 4'h4
`define OFD_R8_LD_HI 4'h5
`define OFD_R8_CMP_EQ 4'h8
`define OFD_GC_ST_HI 4'h2
`define OFD_GC_TRAP 4'h3
`define OFD_GC_LD_HI 4'h6
`define OFD_GC_ADDR 4'h7
`define OFD_GC_LOGIC_HI 4'hB
// index register zero and access size codes
`define OFD_REG_ZERO 4'h0
`define OFD_SZ_BYTE 2'h0
`define OFD_SZ_WORD 2'h1
`define OFD_SZ_LONG 2'h2
`endif

// file: rtl/ofd_pkg.sv
// types shared by the operand field decoder
`default_nettype none
package ofd_pkg;
	typedef enum logic [3:0] {
		FMT_ZERO, FMT_N, FMT_M, FMT_NM, FMT_MD, FMT_ND4,
		FMT_NMD, FMT_D, FMT_D12, FMT_ND8, FMT_I, FMT_NI
	} ofd_fmt_type;
	typedef enum logic [3:0] {
		MODE_NONE, MODE_DIRECT, MODE_INDIRECT, MODE_POSTINC,
		MODE_PREDEC, MODE_DISP, MODE_INDEXED, MODE_GBR_DISP,
		MODE_GBR_INDEXED, MODE_PC_DISP, MODE_PC_REL, MODE_IMM,
		MODE_CTRL, MODE_ACCUM
	} ofd_mode_type;
endpackage
`default_nettype wire

// file: rtl/ofd_decoder.sv
// operand field decoder for fixed 16-bit instruction words
// Functional notes
// - operand roles come from opcode bits, never from field contents.
// - each nibble is opcode, source register, destination register, or part of an immediate or displacement.
// - non-opcode, non-register bits become immediate or displacement.
// - single-destination format: bits 11..8 destination, rest opcode.
// - destination direct or indirect alone, control source copied, or pre-decrement store.
// - single-source: bits 11..8 load control, post-increment, jump or PC offset.
// - register pair: 11..8 destination, 7..4 source, others opcode.
// - multiply-accumulate: bits 11..8 second post-increment source, result to accumulator.
// - pair format supports post-increment source loaded into destination.
// - pair format supports pre-decrement or zero-indexed destination, direct source.
// - register-zero displacement forms: 15..8 opcode, 7..4 base, 3..0 displacement.
// - three-field form: opcode, destination, source, 4-bit displacement.
// - immediate-only: 8-bit immediate versus register zero, global base, or trap.
// - register-immediate: opcode, destination 11..8, immediate 7..0.
// - immediate zero-extended logic, sign-extended arithmetic, trap times four.
// - branch displacements sign-extended and doubled.
// - 4-bit displacement zero-extended, scaled by access size.
`include "ofd_params.svh"
`default_nettype none
module ofd_decoder #(
	parameter int WORD_W = 32
) (
	input wire logic clk, // core clock
	input wire logic resetn, // async reset, active low
	input wire logic instr_valid, // fetch presents a word
	input wire logic [15:0] instr_word, // instruction word
	output logic out_valid, // decoded fields valid
	output var ofd_pkg::ofd_fmt_type fmt, // recognised format
	output var ofd_pkg::ofd_mode_type src_mode, // source role
	output var ofd_pkg::ofd_mode_type dst_mode, // destination role
	output logic [3:0] src_reg, // source register number
	output logic [3:0] dst_reg, // destination register number
	output logic [WORD_W-1:0] imm_ext, // extended immediate
	output logic [WORD_W-1:0] disp_ext // extended, scaled offset
);
	function automatic logic [WORD_W-1:0] zext_scaled(
		input logic [7:0] val, input logic [1:0] size);
		zext_scaled = WORD_W'(val) << size;
	endfunction
	function automatic logic [WORD_W-1:0] sext_doubled(
		input logic [11:0] val);
		sext_doubled = WORD_W'(signed'(val)) << 1;
	endfunction

	logic out_valid_reg, out_valid_next;
	ofd_pkg::ofd_fmt_type fmt_reg, fmt_next;
	ofd_pkg::ofd_mode_type src_mode_reg, src_mode_next;
	ofd_pkg::ofd_mode_type dst_mode_reg, dst_mode_next;
	logic [3:0] src_reg_reg, src_reg_next, dst_reg_reg, dst_reg_next;
	logic [WORD_W-1:0] imm_reg, imm_next, disp_reg, disp_next;
	logic [3:0] grp, hi_f, mid_f, lo_f;
	logic [7:0] low8;

	assign grp = instr_word[15:12];
	assign hi_f = instr_word[11:8];
	assign mid_f = instr_word[7:4];
	assign lo_f = instr_word[3:0];
	assign low8 = instr_word[7:0];

	always_comb begin
		out_valid_next = instr_valid;
		fmt_next = ofd_pkg::FMT_ZERO;
		src_mode_next = ofd_pkg::MODE_NONE;
		dst_mode_next = ofd_pkg::MODE_NONE;
		src_reg_next = `OFD_REG_ZERO;
		dst_reg_next = `OFD_REG_ZERO;
		imm_next = '0;
		disp_next = '0;
		case (grp)
		`OFD_GRP_SYS: begin
			if (lo_f >= `OFD_SYS_IDX_ST_LO && lo_f <= `OFD_SYS_MUL) begin
				fmt_next = ofd_pkg::FMT_NM;
				src_reg_next = mid_f;
				dst_reg_next = hi_f;
				src_mode_next = ofd_pkg::MODE_DIRECT;
				dst_mode_next = (lo_f == `OFD_SYS_MUL) ?
					ofd_pkg::MODE_DIRECT : ofd_pkg::MODE_INDEXED;
			end else if (lo_f >= `OFD_SYS_IDX_LD_LO &&
				lo_f <= `OFD_SYS_IDX_LD_HI) begin
				fmt_next = ofd_pkg::FMT_NM;
				src_reg_next = mid_f;
				dst_reg_next = hi_f;
				src_mode_next = ofd_pkg::MODE_INDEXED;
				dst_mode_next = ofd_pkg::MODE_DIRECT;
			end else if (lo_f == `OFD_SYS_MAC) begin
				fmt_next = ofd_pkg::FMT_NM;
				src_reg_next = mid_f;
				dst_reg_next = hi_f; // second source
				src_mode_next = ofd_pkg::MODE_POSTINC;
				dst_mode_next = ofd_pkg::MODE_ACCUM;
			end else if (lo_f == `OFD_SYS_STC || lo_f == `OFD_SYS_STS) begin
				fmt_next = ofd_pkg::FMT_N;
				dst_reg_next = hi_f;
				src_mode_next = ofd_pkg::MODE_CTRL;
				dst_mode_next = ofd_pkg::MODE_DIRECT;
			end else if (low8 == `OFD_SYS_COPY_T) begin
				fmt_next = ofd_pkg::FMT_N;
				dst_reg_next = hi_f;
				dst_mode_next = ofd_pkg::MODE_DIRECT;
			end else if (lo_f == `OFD_SYS_FAR_RELATIVE_JUMP) begin
				fmt_next = ofd_pkg::FMT_M;
				src_reg_next = hi_f;
				src_mode_next = ofd_pkg::MODE_PC_REL;
			end
		end
		`OFD_GRP_NM_ST, `OFD_GRP_NM_ALU, `OFD_GRP_NM_LD: begin
			fmt_next = ofd_pkg::FMT_NM;
			src_reg_next = mid_f;
			dst_reg_next = hi_f;
			src_mode_next = ofd_pkg::MODE_DIRECT;
			dst_mode_next = ofd_pkg::MODE_DIRECT;
			if (grp == `OFD_GRP_NM_ST) begin
				if (lo_f <= `OFD_IND_HI)
					dst_mode_next = ofd_pkg::MODE_INDIRECT;
				else if (lo_f >= `OFD_AUTO_LO && lo_f <= `OFD_AUTO_HI)
					dst_mode_next = ofd_pkg::MODE_PREDEC;
			end else if (grp == `OFD_GRP_NM_LD) begin
				if (lo_f <= `OFD_IND_HI)
					src_mode_next = ofd_pkg::MODE_INDIRECT;
				else if (lo_f >= `OFD_AUTO_LO && lo_f <= `OFD_AUTO_HI)
					src_mode_next = ofd_pkg::MODE_POSTINC;
			end
		end
		`OFD_GRP_SHIFT: begin
			if (lo_f == `OFD_SH_MAC) begin
				fmt_next = ofd_pkg::FMT_NM;
				src_reg_next = mid_f;
				dst_reg_next = hi_f;
				src_mode_next = ofd_pkg::MODE_POSTINC;
				dst_mode_next = ofd_pkg::MODE_ACCUM;
			end else if (lo_f == `OFD_SH_STORE_LO ||
				lo_f == `OFD_SH_STORE_HI) begin
				fmt_next = ofd_pkg::FMT_N;
				dst_reg_next = hi_f;
				src_mode_next = ofd_pkg::MODE_CTRL;
				dst_mode_next = ofd_pkg::MODE_PREDEC;
			end else if (lo_f == `OFD_SH_LDS || lo_f == `OFD_SH_LDC) begin
				fmt_next = ofd_pkg::FMT_M;
				src_reg_next = hi_f;
				src_mode_next = ofd_pkg::MODE_POSTINC;
				dst_mode_next = ofd_pkg::MODE_CTRL;
			end else if (lo_f == `OFD_SH_LDS_DIRECT ||
				lo_f == `OFD_SH_LDC_DIRECT) begin
				fmt_next = ofd_pkg::FMT_M;
				src_reg_next = hi_f;
				src_mode_next = ofd_pkg::MODE_DIRECT;
				dst_mode_next = ofd_pkg::MODE_CTRL;
			end else if (lo_f == `OFD_SH_JUMP && mid_f != `OFD_SH_TAS) begin
				fmt_next = ofd_pkg::FMT_M;
				src_reg_next = hi_f;
				src_mode_next = ofd_pkg::MODE_DIRECT;
			end else begin
				fmt_next = ofd_pkg::FMT_N;
				dst_reg_next = hi_f;
				dst_mode_next = (lo_f == `OFD_SH_JUMP) ?
					ofd_pkg::MODE_INDIRECT : ofd_pkg::MODE_DIRECT;
			end
		end
		`OFD_GRP_NMD_ST, `OFD_GRP_NMD_LD: begin
			fmt_next = ofd_pkg::FMT_NMD;
			src_reg_next = mid_f;
			dst_reg_next = hi_f;
			disp_next = zext_scaled({4'h0, lo_f}, `OFD_SZ_LONG);
			src_mode_next = (grp == `OFD_GRP_NMD_LD) ?
				ofd_pkg::MODE_DISP : ofd_pkg::MODE_DIRECT;
			dst_mode_next = (grp == `OFD_GRP_NMD_LD) ?
				ofd_pkg::MODE_DIRECT : ofd_pkg::MODE_DISP;
		end
		`OFD_GRP_ADD_IMM, `OFD_GRP_MOV_IMM: begin
			fmt_next = ofd_pkg::FMT_NI;
			dst_reg_next = hi_f;
			src_mode_next = ofd_pkg::MODE_IMM;
			dst_mode_next = ofd_pkg::MODE_DIRECT;
			imm_next = WORD_W'(signed'(low8));
		end
		`OFD_GRP_R0_DISP: begin
			if (hi_f <= `OFD_R8_ST_HI) begin
				fmt_next = ofd_pkg::FMT_ND4;
				src_mode_next = ofd_pkg::MODE_DIRECT;
				dst_reg_next = mid_f;
				dst_mode_next = ofd_pkg::MODE_DISP;
				disp_next = zext_scaled({4'h0, lo_f}, hi_f[1:0]);
			end else if (hi_f == `OFD_R8_LD_LO || hi_f == `OFD_R8_LD_HI) begin
				fmt_next = ofd_pkg::FMT_MD;
				src_reg_next = mid_f;
				src_mode_next = ofd_pkg::MODE_DISP;
				dst_mode_next = ofd_pkg::MODE_DIRECT;
				disp_next = zext_scaled({4'h0, lo_f}, {1'b0, hi_f[0]});
			end else if (hi_f == `OFD_R8_CMP_EQ) begin
				fmt_next = ofd_pkg::FMT_I;
				src_mode_next = ofd_pkg::MODE_IMM;
				dst_mode_next = ofd_pkg::MODE_DIRECT;
				imm_next = WORD_W'(signed'(low8));
			end else if (hi_f[0]) begin
				fmt_next = ofd_pkg::FMT_D;
				src_mode_next = ofd_pkg::MODE_PC_REL;
				disp_next = sext_doubled(12'(signed'(low8)));
			end
		end
		`OFD_GRP_PC_WORD, `OFD_GRP_PC_LONG: begin
			fmt_next = ofd_pkg::FMT_ND8;
			dst_reg_next = hi_f;
			src_mode_next = ofd_pkg::MODE_PC_DISP;
			dst_mode_next = ofd_pkg::MODE_DIRECT;
			disp_next = zext_scaled(low8, (grp == `OFD_GRP_PC_LONG) ?
				`OFD_SZ_LONG : `OFD_SZ_WORD);
		end
		`OFD_GRP_BR12_A, `OFD_GRP_BR12_B: begin
			fmt_next = ofd_pkg::FMT_D12;
			src_mode_next = ofd_pkg::MODE_PC_REL;
			disp_next = sext_doubled(instr_word[11:0]);
		end
		`OFD_GRP_GBR_IMM: begin
			if (hi_f <= `OFD_GC_ST_HI) begin
				fmt_next = ofd_pkg::FMT_D;
				src_mode_next = ofd_pkg::MODE_DIRECT;
				dst_mode_next = ofd_pkg::MODE_GBR_DISP;
				disp_next = zext_scaled(low8, hi_f[1:0]);
			end else if (hi_f == `OFD_GC_TRAP) begin
				fmt_next = ofd_pkg::FMT_I;
				src_mode_next = ofd_pkg::MODE_IMM;
				imm_next = zext_scaled(low8, `OFD_SZ_LONG);
			end else if (hi_f <= `OFD_GC_LD_HI) begin
				fmt_next = ofd_pkg::FMT_D;
				src_mode_next = ofd_pkg::MODE_GBR_DISP;
				dst_mode_next = ofd_pkg::MODE_DIRECT;
				disp_next = zext_scaled(low8, hi_f[1:0]);
			end else if (hi_f == `OFD_GC_ADDR) begin
				fmt_next = ofd_pkg::FMT_D;
				src_mode_next = ofd_pkg::MODE_PC_DISP;
				dst_mode_next = ofd_pkg::MODE_DIRECT;
				disp_next = zext_scaled(low8, `OFD_SZ_LONG);
			end else begin
				fmt_next = ofd_pkg::FMT_I;
				src_mode_next = ofd_pkg::MODE_IMM;
				dst_mode_next = (hi_f <= `OFD_GC_LOGIC_HI) ?
					ofd_pkg::MODE_DIRECT : ofd_pkg::MODE_GBR_INDEXED;
				imm_next = zext_scaled(low8, `OFD_SZ_BYTE);
			end
		end
		default: begin
			fmt_next = ofd_pkg::FMT_ZERO;
		end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			out_valid_reg <= 1'b0;
			fmt_reg <= ofd_pkg::FMT_ZERO;
			src_mode_reg <= ofd_pkg::MODE_NONE;
			dst_mode_reg <= ofd_pkg::MODE_NONE;
			src_reg_reg <= 4'h0;
			dst_reg_reg <= 4'h0;
			imm_reg <= '0;
			disp_reg <= '0;
		end else begin
			out_valid_reg <= out_valid_next;
			fmt_reg <= fmt_next;
			src_mode_reg <= src_mode_next;
			dst_mode_reg <= dst_mode_next;
			src_reg_reg <= src_reg_next;
			dst_reg_reg <= dst_reg_next;
			imm_reg <= imm_next;
			disp_reg <= disp_next;
		end
	end

	assign out_valid = out_valid_reg;
	assign fmt = fmt_reg;
	assign src_mode = src_mode_reg;
	assign dst_mode = dst_mode_reg;
	assign src_reg = src_reg_reg;
	assign dst_reg = dst_reg_reg;
	assign imm_ext = imm_reg;
	assign disp_ext = disp_reg;
endmodule // ofd_decoder
`default_nettype wire

// file: sim/ofd_checker_sva.sv
// assertion checker for the operand field decoder
`default_nettype none
module ofd_checker #(
	parameter int WORD_W = 32
) (
	input wire logic clk, // core clock
	input wire logic resetn, // async reset
	input wire logic instr_valid, // word present
	input wire logic [15:0] instr_word, // word in
	input wire logic out_valid, // result valid
	input wire ofd_pkg::ofd_fmt_type fmt, // format
	input wire ofd_pkg::ofd_mode_type src_mode, // source role
	input wire ofd_pkg::ofd_mode_type dst_mode, // dest role
	input wire logic [3:0] src_reg, // source reg
	input wire logic [3:0] dst_reg, // dest reg
	input wire logic [WORD_W-1:0] imm_ext, // immediate
	input wire logic [WORD_W-1:0] disp_ext // displacement
);
	logic [15:0] w_reg;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn)
			w_reg <= 16'h0000;
		else
			w_reg <= instr_word;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence s_grp(logic [3:0] g);
		resetn && instr_word[15:12] == g;
	endsequence
	a_valid_echo: assert property (resetn |=> out_valid == $past(instr_valid))
		else $error("out_valid lost its word");
	a_pair_regs: assert property (s_grp(4'h3) |=> fmt == ofd_pkg::FMT_NM
		&& dst_reg == w_reg[11:8] && src_reg == w_reg[7:4])
		else $error("pair register fields wrong");
	a_nimm_sext: assert property (s_grp(4'hE) |=> dst_reg == w_reg[11:8]
		&& imm_ext == {{(WORD_W-8){w_reg[7]}}, w_reg[7:0]})
		else $error("register immediate wrong");
	a_br12_disp: assert property (s_grp(4'hA) |=> disp_ext ==
		{{(WORD_W-12){w_reg[11]}}, w_reg[10:0], 1'b0})
		else $error("long branch offset wrong");
	a_trap_scale: assert property (s_grp(4'hC) ##0 instr_word[11:8] == 4'h3
		|=> imm_ext == {w_reg[7:0], 2'b00} && dst_mode == ofd_pkg::MODE_NONE)
		else $error("trap number wrong");
	a_nmd_scale: assert property (s_grp(4'h1) |=> disp_ext == {w_reg[3:0], 2'b00}
		&& src_reg == w_reg[7:4] && dst_mode == ofd_pkg::MODE_DISP)
		else $error("three field offset wrong");
	a_nop_empty: assert property (resetn && instr_word == 16'h0009
		|=> fmt == ofd_pkg::FMT_ZERO && imm_ext == 0 && disp_ext == 0)
		else $error("no operand word gave fields");
	a_mac_roles: assert property (s_grp(4'h0) ##0 instr_word[3:0] == 4'hF
		|=> src_mode == ofd_pkg::MODE_POSTINC && dst_mode == ofd_pkg::MODE_ACCUM)
		else $error("accumulate roles wrong");
	a_nd4_base: assert property (s_grp(4'h8)
		##0 instr_word[11:9] == 3'h0 |=> fmt == ofd_pkg::FMT_ND4
		&& dst_reg == w_reg[7:4] && src_reg == 4'h0)
		else $error("register zero store fields wrong");
endmodule // ofd_checker
bind ofd_decoder ofd_checker #(.WORD_W(WORD_W)) u_ofd_checker (.clk, .resetn,
	.instr_valid, .instr_word, .out_valid, .fmt, .src_mode, .dst_mode,
	.src_reg, .dst_reg, .imm_ext, .disp_ext);
`default_nettype wire

// file: sim/ofd_fetch_model.sv
// fetch stage model presenting instruction words
`default_nettype none
module ofd_fetch_model (
	output var logic instr_valid, // word present
	output var logic [15:0] instr_word // word out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		instr_valid = 1'b0;
		instr_word = 16'h0000;
	end
	task automatic present(input logic [15:0] w);
		instr_valid = 1'b1;
		instr_word = w;
	endtask
	// idle bus shows no stale word
	task automatic idle();
		instr_valid = 1'b0;
		instr_word = ~instr_word;
	endtask
endmodule // ofd_fetch_model
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the operand field decoder
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, resetn, out_valid, instr_valid;
	logic [15:0] instr_word;
	ofd_pkg::ofd_fmt_type fmt;
	ofd_pkg::ofd_mode_type src_mode, dst_mode;
	logic [3:0] src_reg, dst_reg;
	logic [31:0] imm_ext, disp_ext;
	int bad_count = 0;
	int check_count = 0;
	ofd_fetch_model u_fetch (.instr_valid(instr_valid),
		.instr_word(instr_word));
	ofd_decoder u_ofd_decoder (.clk(clk), .resetn(resetn),
		.instr_valid(instr_valid), .instr_word(instr_word),
		.out_valid(out_valid), .fmt(fmt), .src_mode(src_mode),
		.dst_mode(dst_mode), .src_reg(src_reg), .dst_reg(dst_reg),
		.imm_ext(imm_ext), .disp_ext(disp_ext));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic dec(input logic [15:0] w, input ofd_pkg::ofd_fmt_type f,
		input ofd_pkg::ofd_mode_type sm, dm, input logic [3:0] s, d,
		input logic [31:0] im, ds);
		u_fetch.present(w);
		@(negedge clk);
		`CHK(out_valid, 1'b1)
		`CHK(fmt, f)
		`CHK(src_mode, sm)
		`CHK(dst_mode, dm)
		`CHK(src_reg, s)
		`CHK(dst_reg, d)
		`CHK(imm_ext, im)
		`CHK(disp_ext, ds)
	endtask
	task automatic t_pair();
		dec(16'h6125, ofd_pkg::FMT_NM, ofd_pkg::MODE_POSTINC,
			ofd_pkg::MODE_DIRECT, 4'h2, 4'h1, 32'h0, 32'h0);
		dec(16'h2136, ofd_pkg::FMT_NM, ofd_pkg::MODE_DIRECT,
			ofd_pkg::MODE_PREDEC, 4'h3, 4'h1, 32'h0, 32'h0);
		dec(16'h0ABF, ofd_pkg::FMT_NM, ofd_pkg::MODE_POSTINC,
			ofd_pkg::MODE_ACCUM, 4'hB, 4'hA, 32'h0, 32'h0);
		dec(16'h0126, ofd_pkg::FMT_NM, ofd_pkg::MODE_DIRECT,
			ofd_pkg::MODE_INDEXED, 4'h2, 4'h1, 32'h0, 32'h0);
		dec(16'h012C, ofd_pkg::FMT_NM, ofd_pkg::MODE_INDEXED,
			ofd_pkg::MODE_DIRECT, 4'h2, 4'h1, 32'h0, 32'h0);
		dec(16'h2122, ofd_pkg::FMT_NM, ofd_pkg::MODE_DIRECT,
			ofd_pkg::MODE_INDIRECT, 4'h2, 4'h1, 32'h0, 32'h0);
		dec(16'h312C, ofd_pkg::FMT_NM, ofd_pkg::MODE_DIRECT,
			ofd_pkg::MODE_DIRECT, 4'h2, 4'h1, 32'h0, 32'h0);
		$display("done: register pair");
	endtask
	task automatic t_single();
		dec(16'h0229, ofd_pkg::FMT_N, ofd_pkg::MODE_NONE,
			ofd_pkg::MODE_DIRECT, 4'h0, 4'h2, 32'h0, 32'h0);
		dec(16'h4D03, ofd_pkg::FMT_N, ofd_pkg::MODE_CTRL,
			ofd_pkg::MODE_PREDEC, 4'h0, 4'hD, 32'h0, 32'h0);
		dec(16'h4707, ofd_pkg::FMT_M, ofd_pkg::MODE_POSTINC,
			ofd_pkg::MODE_CTRL, 4'h7, 4'h0, 32'h0, 32'h0);
		dec(16'h0C23, ofd_pkg::FMT_M, ofd_pkg::MODE_PC_REL,
			ofd_pkg::MODE_NONE, 4'hC, 4'h0, 32'h0, 32'h0);
		dec(16'h4A0B, ofd_pkg::FMT_M, ofd_pkg::MODE_DIRECT,
			ofd_pkg::MODE_NONE, 4'hA, 4'h0, 32'h0, 32'h0);
		dec(16'h4A1B, ofd_pkg::FMT_N, ofd_pkg::MODE_NONE,
			ofd_pkg::MODE_INDIRECT, 4'h0, 4'hA, 32'h0, 32'h0);
		dec(16'h4A0E, ofd_pkg::FMT_M, ofd_pkg::MODE_DIRECT,
			ofd_pkg::MODE_CTRL, 4'hA, 4'h0, 32'h0, 32'h0);
		dec(16'h0A0A, ofd_pkg::FMT_N, ofd_pkg::MODE_CTRL,
			ofd_pkg::MODE_DIRECT, 4'h0, 4'hA, 32'h0, 32'h0);
		$display("done: single register");
	endtask
	task automatic t_disp();
		dec(16'h8523, ofd_pkg::FMT_MD, ofd_pkg::MODE_DISP,
			ofd_pkg::MODE_DIRECT, 4'h2, 4'h0, 32'h0, 32'h6);
		dec(16'h8013, ofd_pkg::FMT_ND4, ofd_pkg::MODE_DIRECT,
			ofd_pkg::MODE_DISP, 4'h0, 4'h1, 32'h0, 32'h3);
		dec(16'h1123, ofd_pkg::FMT_NMD, ofd_pkg::MODE_DIRECT,
			ofd_pkg::MODE_DISP, 4'h2, 4'h1, 32'h0, 32'hC);
		dec(16'h5123, ofd_pkg::FMT_NMD, ofd_pkg::MODE_DISP,
			ofd_pkg::MODE_DIRECT, 4'h2, 4'h1, 32'h0, 32'hC);
		dec(16'hC1FF, ofd_pkg::FMT_D, ofd_pkg::MODE_DIRECT,
			ofd_pkg::MODE_GBR_DISP, 4'h0, 4'h0, 32'h0, 32'h1FE);
		dec(16'hC6FF, ofd_pkg::FMT_D, ofd_pkg::MODE_GBR_DISP,
			ofd_pkg::MODE_DIRECT, 4'h0, 4'h0, 32'h0, 32'h3FC);
		dec(16'hC7FF, ofd_pkg::FMT_D, ofd_pkg::MODE_PC_DISP,
			ofd_pkg::MODE_DIRECT, 4'h0, 4'h0, 32'h0, 32'h3FC);
		$display("done: displacement");
	endtask
	task automatic t_imm();
		dec(16'hC3FF, ofd_pkg::FMT_I, ofd_pkg::MODE_IMM,
			ofd_pkg::MODE_NONE, 4'h0, 4'h0, 32'h3FC, 32'h0);
		dec(16'hE1FF, ofd_pkg::FMT_NI, ofd_pkg::MODE_IMM,
			ofd_pkg::MODE_DIRECT, 4'h0, 4'h1, 32'hFFFFFFFF, 32'h0);
		dec(16'hC9F0, ofd_pkg::FMT_I, ofd_pkg::MODE_IMM,
			ofd_pkg::MODE_DIRECT, 4'h0, 4'h0, 32'hF0, 32'h0);
		dec(16'h8880, ofd_pkg::FMT_I, ofd_pkg::MODE_IMM,
			ofd_pkg::MODE_DIRECT, 4'h0, 4'h0, 32'hFFFFFF80, 32'h0);
		dec(16'hCDF0, ofd_pkg::FMT_I, ofd_pkg::MODE_IMM,
			ofd_pkg::MODE_GBR_INDEXED, 4'h0, 4'h0, 32'hF0, 32'h0);
		dec(16'h70FF, ofd_pkg::FMT_NI, ofd_pkg::MODE_IMM,
			ofd_pkg::MODE_DIRECT, 4'h0, 4'h0, 32'hFFFFFFFF, 32'h0);
		$display("done: immediate");
	endtask
	task automatic t_branch();
		dec(16'hA801, ofd_pkg::FMT_D12, ofd_pkg::MODE_PC_REL,
			ofd_pkg::MODE_NONE, 4'h0, 4'h0, 32'h0, 32'hFFFFF002);
		dec(16'hB7FF, ofd_pkg::FMT_D12, ofd_pkg::MODE_PC_REL,
			ofd_pkg::MODE_NONE, 4'h0, 4'h0, 32'h0, 32'hFFE);
		dec(16'h8B80, ofd_pkg::FMT_D, ofd_pkg::MODE_PC_REL,
			ofd_pkg::MODE_NONE, 4'h0, 4'h0, 32'h0, 32'hFFFFFF00);
		dec(16'hD3FF, ofd_pkg::FMT_ND8, ofd_pkg::MODE_PC_DISP,
			ofd_pkg::MODE_DIRECT, 4'h0, 4'h3, 32'h0, 32'h3FC);
		dec(16'h9AFF, ofd_pkg::FMT_ND8, ofd_pkg::MODE_PC_DISP,
			ofd_pkg::MODE_DIRECT, 4'h0, 4'hA, 32'h0, 32'h1FE);
		$display("done: branch");
	endtask
	task automatic t_empty();
		dec(16'h0009, ofd_pkg::FMT_ZERO, ofd_pkg::MODE_NONE,
			ofd_pkg::MODE_NONE, 4'h0, 4'h0, 32'h0, 32'h0);
		dec(16'hF123, ofd_pkg::FMT_ZERO, ofd_pkg::MODE_NONE,
			ofd_pkg::MODE_NONE, 4'h0, 4'h0, 32'h0, 32'h0);
		u_fetch.idle();
		@(negedge clk);
		`CHK(out_valid, 1'b0)
		$display("done: no operand and idle");
	endtask
	// reset dropped while a decoded word stands
	task automatic t_reset();
		u_fetch.present(16'h6125);
		@(negedge clk);
		`CHK(out_valid, 1'b1)
		resetn = 1'b0;
		#1;
		`CHK(out_valid, 1'b0)
		`CHK(src_mode, ofd_pkg::MODE_NONE)
		`CHK(src_reg, 4'h0)
		@(negedge clk);
		`CHK(fmt, ofd_pkg::FMT_ZERO)
		resetn = 1'b1;
		dec(16'hE1FF, ofd_pkg::FMT_NI, ofd_pkg::MODE_IMM,
			ofd_pkg::MODE_DIRECT, 4'h0, 4'h1, 32'hFFFFFFFF, 32'h0);
		$display("done: reset in flight");
	endtask
	initial begin
		resetn = 1'b0;
		repeat (6) @(posedge clk);
		@(negedge clk);
		`CHK(out_valid, 1'b0)
		`CHK(fmt, ofd_pkg::FMT_ZERO)
		resetn = 1'b1;
		t_pair();
		t_single();
		t_disp();
		t_imm();
		t_branch();
		t_empty();
		t_reset();
		finish_test();
	end
	initial begin
		repeat (200) @(posedge clk);
		bad_count++;
		finish_test();
	end
endmodule // testbench
`default_nettype wire
